// [adc_dac_sequencer_fifo.v]
/*
  Serial-port control of a multichannel 12-bit ADC and quad DAC:
  command decode, setup and mode registers, conversion sequencer,
  result FIFO with temperature slot, double-buffered DAC registers.
  Assumes serial and control pins arrive asynchronous to clk and the analog core
  answers each adc_start with one adc_done pulse on clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_dac_sequencer_fifo_consts.vh"

module adc_dac_sequencer_fifo (
  input wire clk,
  input wire nrst,
  input wire cs_n,
  input wire sclk,
  input wire din,
  input wire convert_start_n,
  input wire dac_load_n,
  input wire dac_wake_level_sel,
  input wire adc_done,
  input wire [12:0] adc_raw,
  output reg dout,
  output reg eoc_n,
  output reg adc_start,
  output reg [2:0] adc_channel,
  output reg adc_diff,
  output reg adc_bipolar,
  output reg adc_temp_sel,
  output reg avg_enable,
  output reg [1:0] clk_mode,
  output reg [1:0] ref_source_sel,
  output reg [47:0] dac_code
);

  localparam S_IDLE = 3'b001;
  localparam S_ISSUE = 3'b010;
  localparam S_WAIT = 3'b100;
  localparam P_CMD = 4'b0001;
  localparam P_MODE = 4'b0010;
  localparam P_DAC1 = 4'b0100;
  localparam P_DAC2 = 4'b1000;

  // Two-flop synchronisers; stage 3 only feeds edge detection
  reg [2:0] cs_s, sck_s, cnv_s, ld_s;
  reg [1:0] din_s, wake_s;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_s <= 3'h7;
      sck_s <= 3'h0;
      cnv_s <= 3'h7;
      ld_s <= 3'h7;
      din_s <= 2'h0;
      wake_s <= 2'h0;
    end else begin
      cs_s <= {cs_s[1:0], cs_n};
      sck_s <= {sck_s[1:0], sclk};
      cnv_s <= {cnv_s[1:0], convert_start_n};
      ld_s <= {ld_s[1:0], dac_load_n};
      din_s <= {din_s[0], din};
      wake_s <= {wake_s[0], dac_wake_level_sel};
    end
  end

  wire cs_low = ~cs_s[1];
  wire cs_fall = cs_s[2] & ~cs_s[1];
  wire sck_fall = sck_s[2] & ~sck_s[1];
  wire sck_rise = ~sck_s[2] & sck_s[1];
  wire cnv_fall = cnv_s[2] & ~cnv_s[1];
  wire ld_fall = ld_s[2] & ~ld_s[1];

  reg [7:0] setup_reg, conv_reg, uni_reg, bip_reg, avg_reg;
  reg [3:0] phase_reg;
  reg [2:0] bit_cnt_reg;
  reg [6:0] rx_reg;
  reg [7:0] dac_hi_reg;
  reg conv_trig_reg;
  reg dac_wr_reg;
  reg [15:0] dac_word_reg;
  wire [1:0] mode = setup_reg[5:4];
  wire [7:0] rx_byte = {rx_reg, din_s[1]};
  wire byte_done = cs_low & sck_fall & (bit_cnt_reg == 3'h7);

  // Serial receive and command decode
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      setup_reg <= `SETUP_RESET;
      conv_reg <= 8'h00;
      uni_reg <= 8'h00;
      bip_reg <= 8'h00;
      avg_reg <= 8'h00;
      phase_reg <= P_CMD;
      bit_cnt_reg <= 3'h0;
      rx_reg <= 7'h00;
      dac_hi_reg <= 8'h00;
      conv_trig_reg <= 1'b0;
      dac_wr_reg <= 1'b0;
      dac_word_reg <= 16'h0000;
    end else begin
      conv_trig_reg <= 1'b0;
      dac_wr_reg <= 1'b0;
      if (!cs_low) begin
        phase_reg <= P_CMD;
        bit_cnt_reg <= 3'h0;
      end else if (sck_fall) begin
        rx_reg <= rx_byte[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      if (byte_done) begin
        case (phase_reg)
          P_CMD: begin
            if (rx_byte[7]) begin
              conv_reg <= rx_byte;
              conv_trig_reg <= mode[1];
            end else if (rx_byte[7:6] == `SETUP_HDR) begin
              setup_reg <= rx_byte;
              if (rx_byte[1])
                phase_reg <= P_MODE;
            end else if (rx_byte[7:5] == `AVG_HDR) begin
              avg_reg <= rx_byte;
            end else if (rx_byte[7:4] == `DAC_HDR) begin
              phase_reg <= P_DAC1;
            end
          end
          P_MODE: begin
            if (setup_reg[1:0] == `DIFF_BIP_NEXT)
              bip_reg <= rx_byte;
            else
              uni_reg <= rx_byte;
            phase_reg <= P_CMD;
          end
          P_DAC1: begin
            dac_hi_reg <= rx_byte;
            phase_reg <= P_DAC2;
          end
          P_DAC2: begin
            dac_word_reg <= {dac_hi_reg, rx_byte};
            dac_wr_reg <= 1'b1;
            phase_reg <= P_CMD;
          end
          default: phase_reg <= P_CMD;
        endcase
      end
    end
  end

  // Conversion sequencer
  reg [2:0] state_reg;
  reg [3:0] ch_reg, last_reg;
  reg temp_pend_reg;
  wire [1:0] pair = ch_reg[2:1];
  wire is_diff = uni_reg[pair] | bip_reg[pair];
  wire single_only = (mode == `MODE_CNV_EXT) | (mode == `MODE_SER_CLK);
  wire [3:0] ch_next = is_diff ? ({ch_reg[3:1], 1'b0} + 4'h2) :
                       (ch_reg + 4'h1);
  wire cnv_trig = cnv_fall & ~mode[1];
  wire go = cnv_trig | conv_trig_reg;
  wire res_done = (state_reg == S_WAIT) & adc_done;
  wire push = res_done & ~temp_pend_reg;
  wire temp_wr = res_done & temp_pend_reg;
  wire scan_one = single_only | conv_reg[2];

  function [11:0] fmt;
    input [12:0] raw;
    input bip;
    input tmp;
    begin
      if (tmp)
        fmt = raw[11:0];
      else if (bip)
        fmt = raw[12:1];
      else
        fmt = raw[12] ? 12'h000 : raw[11:0];
    end
  endfunction

  wire [11:0] result = fmt(adc_raw, adc_bipolar, adc_temp_sel);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      ch_reg <= 4'h0;
      last_reg <= 4'h0;
      temp_pend_reg <= 1'b0;
      adc_start <= 1'b0;
      adc_channel <= 3'h0;
      adc_diff <= 1'b0;
      adc_bipolar <= 1'b0;
      adc_temp_sel <= 1'b0;
      eoc_n <= 1'b1;
    end else begin
      adc_start <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            last_reg <= {1'b0, conv_reg[5:3]};
            ch_reg <= scan_one ? {1'b0, conv_reg[5:3]} : 4'h0;
            temp_pend_reg <= conv_reg[0];
            state_reg <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          adc_start <= 1'b1;
          adc_temp_sel <= temp_pend_reg;
          adc_diff <= is_diff;
          adc_channel <= is_diff ? {ch_reg[2:1], 1'b0} : ch_reg[2:0];
          adc_bipolar <= is_diff & bip_reg[pair];
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (adc_done) begin
            if (temp_pend_reg) begin
              temp_pend_reg <= 1'b0;
              state_reg <= S_ISSUE;
            end else if (scan_one || ch_next > last_reg) begin
              state_reg <= S_IDLE;
              if (mode != `MODE_SER_CLK)
                eoc_n <= 1'b0;
            end else begin
              ch_reg <= ch_next;
              state_reg <= S_ISSUE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      if (mode == `MODE_SER_CLK || cs_fall || cnv_fall)
        eoc_n <= 1'b1;
    end
  end

  // Result FIFO, temperature slot and serial readout
  reg [11:0] fifo_mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW-1:0] wr_ptr_reg, rd_ptr_reg;
  reg [`FIFO_AW:0] count_reg;
  reg temp_valid_reg;
  reg [11:0] temp_reg;
  reg [15:0] tx_reg;
  reg [3:0] tx_cnt_reg;
  reg [1:0] src_reg;
  wire tx_edge = (mode == `MODE_SER_CLK) ? sck_rise : sck_fall;
  wire wrap = cs_low & tx_edge & (tx_cnt_reg == 4'hF);
  wire load = cs_fall | wrap;
  wire full = count_reg[`FIFO_AW];
  wire pop = wrap & src_reg[1] & (count_reg != 5'h00);
  wire temp_clr = wrap & src_reg[0];
  wire temp_avail = temp_valid_reg & ~temp_clr;
  wire [4:0] cnt_left = count_reg - {4'h0, pop};
  wire [3:0] head = rd_ptr_reg + {3'h0, pop};
  wire [15:0] next_pair = temp_avail ? {4'h0, temp_reg} :
                          (cnt_left != 5'h00) ? {4'h0, fifo_mem[head]} :
                          16'h0000;

  always @(posedge clk) begin
    if (push)
      fifo_mem[wr_ptr_reg] <= result;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg <= 5'h00;
      temp_valid_reg <= 1'b0;
      temp_reg <= 12'h000;
      tx_reg <= 16'h0000;
      tx_cnt_reg <= 4'h0;
      src_reg <= 2'h0;
      dout <= 1'b0;
    end else begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      if (pop || (push && full))
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      if (push && !full && !pop)
        count_reg <= count_reg + 5'h01;
      else if (pop && !push)
        count_reg <= count_reg - 5'h01;
      if (temp_wr) begin
        temp_reg <= result;
        temp_valid_reg <= 1'b1;
      end else if (temp_clr)
        temp_valid_reg <= 1'b0;
      if (load) begin
        tx_reg <= {next_pair[14:0], 1'b0};
        src_reg <= {~temp_avail & (cnt_left != 5'h00), temp_avail};
        dout <= next_pair[15];
        tx_cnt_reg <= 4'h0;
      end else if (cs_low && tx_edge) begin
        tx_reg <= {tx_reg[14:0], 1'b0};
        dout <= tx_reg[15];
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end
    end
  end

  // DAC input and output registers
  reg [47:0] dac_in_reg;
  reg [1:0] init_reg;
  wire [1:0] dsel = dac_word_reg[13:12];
  wire [11:0] wake_val = wake_s[1] ? `DAC_ONES : `DAC_ZERO;
  integer i;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_reg <= 2'h0;
      dac_in_reg <= 48'h000000000000;
      dac_code <= 48'h000000000000;
      clk_mode <= 2'h0;
      ref_source_sel <= 2'h0;
      avg_enable <= 1'b0;
    end else begin
      clk_mode <= mode;
      ref_source_sel <= setup_reg[3:2];
      avg_enable <= avg_reg[4] & (mode != `MODE_SER_CLK);
      if (init_reg != `INIT_DONE)
        init_reg <= init_reg + 2'h1;
      if (init_reg == `INIT_CAPTURE) begin
        dac_in_reg <= {4{wake_val}};
        dac_code <= {4{wake_val}};
      end else begin
        if (dac_wr_reg &&
            dac_word_reg[15:12] == `DAC_CODE_LOAD_ALL)
          dac_code <= dac_in_reg;
        else if (dac_wr_reg) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (dsel == i[1:0]) begin
              dac_in_reg[i*12 +: 12] <= dac_word_reg[11:0];
              if (dac_word_reg[15:14] == `DAC_CODE_WR_LOAD)
                dac_code[i*12 +: 12] <= dac_word_reg[11:0];
            end
          end
        end
        if (ld_fall)
          dac_code <= dac_in_reg;
      end
    end
  end

endmodule // adc_dac_sequencer_fifo
`default_nettype wire

// [adc_dac_sequencer_fifo_consts.vh]
/*
  Constants of the converter control block: command codes, register
  reset values, clock modes, FIFO size and DAC word layout.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef ADC_DAC_SEQUENCER_FIFO_CONSTS_VH
`define ADC_DAC_SEQUENCER_FIFO_CONSTS_VH

`define SETUP_RESET 8'h28
`define SETUP_HDR 2'h1
`define AVG_HDR 3'h1
`define DAC_HDR 4'h1
`define MODE_CNV_INT 2'h0
`define MODE_CNV_EXT 2'h1
`define MODE_SER_INT 2'h2
`define MODE_SER_CLK 2'h3
`define DIFF_UNI_NEXT 2'h2
`define DIFF_BIP_NEXT 2'h3
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define DAC_CODE_WR 2'h0
`define DAC_CODE_WR_LOAD 2'h2
`define DAC_CODE_LOAD_ALL 4'hF
`define DAC_ZERO 12'h000
`define DAC_ONES 12'hFFF
`define INIT_CAPTURE 2'h2
`define INIT_DONE 2'h3

`endif

// [adc_dac_checker_assertions.sv]
/* Port assertions for the converter control block.
   Assumes one clk domain with async active-low nrst. */
`timescale 1ns/100ps
`default_nettype none
module adc_dac_checker (
  input wire clk,
  input wire nrst,
  input wire cs_n,
  input wire convert_start_n,
  input wire dac_wake_level_sel,
  input wire adc_done,
  input wire eoc_n,
  input wire adc_start,
  input wire [2:0] adc_channel,
  input wire adc_diff,
  input wire adc_bipolar,
  input wire adc_temp_sel,
  input wire avg_enable,
  input wire [1:0] clk_mode,
  input wire [1:0] ref_source_sel,
  input wire [47:0] dac_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_setup_rst;
    $rose(nrst) |=> clk_mode == 2'h2 && ref_source_sel == 2'h2;
  endproperty
  a_setup_rst: assert property (p_setup_rst) else $error("setup reset");
  property p_dac_wake;
    $rose(nrst) |-> ##6 dac_code == {48{dac_wake_level_sel}};
  endproperty
  a_dac_wake: assert property (p_dac_wake) else $error("dac wake");
  property p_eoc_m11;
    (clk_mode == 2'h3)[*2] |-> eoc_n;
  endproperty
  a_eoc_m11: assert property (p_eoc_m11) else $error("eoc mode 11");
  property p_avg_m11;
    (clk_mode == 2'h3)[*2] |-> !avg_enable;
  endproperty
  a_avg_m11: assert property (p_avg_m11) else $error("avg mode 11");
  property p_eoc_cs;
    $fell(cs_n) |-> ##[1:5] eoc_n;
  endproperty
  a_eoc_cs: assert property (p_eoc_cs) else $error("eoc on cs");
  property p_eoc_cnv;
    $fell(convert_start_n) |-> ##[1:5] eoc_n;
  endproperty
  a_eoc_cnv: assert property (p_eoc_cnv) else $error("eoc on cnv");
  property p_eoc_done;
    $fell(eoc_n) |-> $past(adc_done);
  endproperty
  a_eoc_done: assert property (p_eoc_done) else $error("eoc early");
  property p_start_one;
    adc_start |=> !adc_start;
  endproperty
  a_start_one: assert property (p_start_one) else $error("start pulse");
  property p_diff_even;
    adc_start && adc_diff |-> !adc_channel[0];
  endproperty
  a_diff_even: assert property (p_diff_even) else $error("odd pair");
  property p_single_uni;
    adc_start && !adc_diff && !adc_temp_sel |-> !adc_bipolar;
  endproperty
  a_single_uni: assert property (p_single_uni) else $error("se bipolar");
endmodule // adc_dac_checker

bind adc_dac_sequencer_fifo adc_dac_checker chk_i (.clk, .nrst, .cs_n,
  .convert_start_n, .dac_wake_level_sel, .adc_done, .eoc_n, .adc_start,
  .adc_channel, .adc_diff, .adc_bipolar, .adc_temp_sel, .avg_enable,
  .clk_mode, .ref_source_sel, .dac_code);
`default_nettype wire

// [spi_master_model.sv]
/* Serial master model, sclk idle low, 200 ns period.
   Assumes the device takes din on sclk fall. */
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task xfer(input [23:0] tx, input integer n, output [23:0] rx);
    integer i;
    rx = 24'h0;
    cs_n = 1'b0;
    #100;
    for (i = n - 1; i >= 0; i--) begin
      din = tx[i];
      sclk = 1'b1;
      #100;
      rx = {rx[22:0], dout};
      sclk = 1'b0;
      #100;
    end
    cs_n = 1'b1;
    din = ~din; // Released line shows no stale data
    #400;
  endtask
endmodule // spi_master_model
`default_nettype wire

// [adc_dac_sequencer_fifo_tb_top.sv]
/* Testbench: master model, analog core model, scenarios.
   Assumes the consts header and design are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module adc_dac_sequencer_fifo_tb_top;
  logic clk = 1'b0;
  logic nrst, convert_start_n, dac_load_n, dac_wake_level_sel;
  logic adc_done = 1'b0;
  logic [12:0] adc_raw = 13'h0000;
  logic [2:0] dly = 3'h0;
  wire logic cs_n, sclk, din, dout, eoc_n, adc_start, adc_diff, adc_bipolar;
  wire logic adc_temp_sel, avg_enable;
  wire logic [2:0] adc_channel;
  wire logic [1:0] clk_mode, ref_source_sel;
  wire logic [47:0] dac_code;
  logic [23:0] rx;
  integer err_total = 0;
  integer n_checks = 0;
  integer j;
  always #12.5 clk = ~clk;
  adc_dac_sequencer_fifo dut (.clk, .nrst, .cs_n, .sclk, .din,
    .convert_start_n, .dac_load_n, .dac_wake_level_sel, .adc_done,
    .adc_raw, .dout, .eoc_n, .adc_start, .adc_channel, .adc_diff,
    .adc_bipolar, .adc_temp_sel, .avg_enable, .clk_mode, .ref_source_sel,
    .dac_code);
  spi_master_model master (.cs_n, .sclk, .din, .dout);
  // Analog core answers each start four cycles later
  always @(negedge clk) begin
    dly <= {dly[1:0], adc_start};
    adc_done <= dly[2];
    adc_raw <= adc_temp_sel ? 13'h0F38 : adc_diff ? 13'h1F00 :
      {10'h0A0, adc_channel};
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string s, input [47:0] e, input [47:0] g);
    n_checks++;
    if (e !== g) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task wr(input [23:0] v, input integer n);
    master.xfer(v, n, rx);
  endtask
  task rd(input [15:0] e);
    master.xfer(24'h0, 16, rx);
    chk("result", {32'h0, e}, {32'h0, rx[15:0]});
  endtask
  task wait_eoc;
    integer k;
    for (k = 0; k < 400 && eoc_n !== 1'b0; k++) @(negedge clk);
    chk("eoc_n", 48'h0, {47'h0, eoc_n});
  endtask
  task pulse(input integer which);
    @(negedge clk);
    if (which == 0) convert_start_n = 1'b0;
    else dac_load_n = 1'b0;
    repeat (4) @(negedge clk);
    convert_start_n = 1'b1;
    dac_load_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task do_reset(input logic s);
    dac_wake_level_sel = s;
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task t_reset(input [47:0] d);
    chk("clk_mode", 48'h2, {46'h0, clk_mode});
    chk("ref_sel", 48'h2, {46'h0, ref_source_sel});
    chk("dac_code", d, dac_code);
    chk("eoc_n", 48'h1, {47'h0, eoc_n});
    chk("avg", 48'h0, {47'h0, avg_enable});
  endtask
  task t_seq;
    wr(24'h91, 8);
    wait_eoc;
    rd(16'h0F38);
    rd(16'h0500);
    rd(16'h0501);
    rd(16'h0502);
    rd(16'h0000);
  endtask
  task t_over;
    for (j = 0; j < 17; j++) begin
      wr(24'(8'h84 + 8 * (j % 8)), 8);
      wait_eoc;
    end
    for (j = 0; j < 16; j++) rd(16'(16'h0500 + (j + 1) % 8));
    rd(16'h0000);
  endtask
  task t_cnv;
    wr(24'h48, 8);
    chk("mode", 48'h0, {46'h0, clk_mode});
    wr(24'h84, 8);
    repeat (20) @(negedge clk);
    chk("eoc_n", 48'h1, {47'h0, eoc_n});
    pulse(0);
    wait_eoc;
    rd(16'h0500);
    wr(24'h58, 8);
    wr(24'h88, 8);
    pulse(0);
    wait_eoc;
    rd(16'h0501);
    rd(16'h0000);
  endtask
  task t_diff;
    wr(24'h6A01, 16);
    wr(24'h6B02, 16);
    wr(24'h8C, 8);
    wait_eoc;
    chk("diff", 48'h1, {47'h0, adc_diff});
    wr(24'h9C, 8);
    wait_eoc;
    chk("chan", 48'h2, {45'h0, adc_channel});
    chk("bip", 48'h1, {47'h0, adc_bipolar});
    rd(16'h0000);
    rd(16'h0F80);
    wr(24'hAC, 8);
    wait_eoc;
    rd(16'h0505);
    wr(24'h30, 8);
    chk("avg_on", 48'h1, {47'h0, avg_enable});
  endtask
  task t_m11;
    wr(24'h78, 8);
    chk("mode", 48'h3, {46'h0, clk_mode});
    chk("eoc_n", 48'h1, {47'h0, eoc_n});
    chk("avg_off", 48'h0, {47'h0, avg_enable});
  endtask
  task t_dac;
    wr(24'h102ABC, 24);
    chk("hold", 48'h0, dac_code);
    pulse(1);
    chk("load", 48'h000ABC000000, dac_code);
    wr(24'h109123, 24);
    chk("wr_load", 48'h000ABC123000, dac_code);
    wr(24'h010355, 20);
    pulse(1);
    chk("abort", 48'h000ABC123000, dac_code);
    wr(24'h10A777, 24);
    chk("after_abort", 48'h000777123000, dac_code);
  endtask
  initial begin
    convert_start_n = 1'b1;
    dac_load_n = 1'b1;
    do_reset(1'b1);
    t_reset(48'hFFFFFFFFFFFF);
    t_seq;
    t_over;
    t_cnv;
    t_diff;
    t_m11;
    do_reset(1'b0);
    t_reset(48'h0);
    t_dac;
    tally_and_finish;
  end
  initial begin
    #1_000_000;
    err_total++;
    tally_and_finish;
  end
endmodule // adc_dac_sequencer_fifo_tb_top
`default_nettype wire
